// file: plcs_link_regs.sv
`timescale 1ns/1ps
// Behaviour
// - aspm field: 0 off, 1 l0s, 2 l1, 3 both entries enabled
// - receiver l0s entry stays allowed even when aspm is off
// - read completion boundary bit always reads zero
// - link disable takes downstream link down; upstream hardwired zero
// - retrain write starts retraining downstream; upstream hardwired zero
// - retrain bit always reads zero
// - common clock bit writable, resets to zero
// - extended sync sends 4096 fts or 1024 ts1 on exits
// - bits 10 and 11 read-only upstream, writable downstream, reset zero
// - speed field reports 1 or 2, resets to 5 gb/s code
// - width field reports trained lanes, resets to one lane
// - training error set on failure, cleared on reaching l0
// - training flag set while training runs, cleared on completion
// - slot clock bit reset value caught from strap pin
// - bit 29 reads one while data link is active, three clocks behind the pin
// - hardware width change inhibit is writable, resets zero
module plcs_link_regs
(
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        slot_clock_strap,
	input  wire logic        ltssm_training,
	input  wire logic        ltssm_train_fail,
	input  wire logic        ltssm_in_l0,
	input  wire logic        dl_active,
	input  wire logic        speed_5g,
	input  wire logic [5:0]  trained_width,
	input  wire logic        width_valid,
	output logic             link_disable,
	output logic             retrain_pulse,
	output logic [1:0]       aspm_enable,
	output logic             rx_l0s_allowed,
	output logic             common_clock,
	output logic             hw_width_change_inhibit,
	output logic [12:0]      l0s_exit_fts,
	output logic [12:0]      l1_exit_ts1,
	output logic             irq
);
	localparam int IRQ_W = plcs_pkg::IRQ_W;

	logic [15:0]        ctrl_q;
	logic [3:0]         speed_q;
	logic [5:0]         width_q;
	logic               terr_q;
	logic               training_q;
	logic               slot_clk_q;
	logic               strap_done_q;
	logic [1:0]         strap_arm_q;
	logic               dl_act_q;
	logic               dl_act_prev_q;
	logic               is_down_q;
	logic [IRQ_W-1:0]   irq_sts_q;
	logic [IRQ_W-1:0]   irq_mask_q;
	logic [IRQ_W-1:0]   irq_evt;
	logic [15:0]        rw_mask;
	logic [15:0]        wmask;
	logic [31:0]        rdata_d;
	logic               wr_acc;
	logic               rd_acc;
	logic               hit_link;
	logic               strap_s;
	logic               train_s;
	logic               fail_s;
	logic               l0_s;
	logic               dl_s;
	logic               spd_s;
	logic               train_prev_q;

	localparam logic [11:0] ADDR_LINK = plcs_pkg::LINK_CTRL_STS_ADDR;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	plcs_sync u_sync_strap (.mclk(mclk), .reset(reset),
		.async_in(slot_clock_strap), .sync_out(strap_s));
	plcs_sync u_sync_train (.mclk(mclk), .reset(reset),
		.async_in(ltssm_training), .sync_out(train_s));
	plcs_sync u_sync_fail (.mclk(mclk), .reset(reset),
		.async_in(ltssm_train_fail), .sync_out(fail_s));
	plcs_sync u_sync_l0 (.mclk(mclk), .reset(reset),
		.async_in(ltssm_in_l0), .sync_out(l0_s));
	plcs_sync u_sync_dl (.mclk(mclk), .reset(reset),
		.async_in(dl_active), .sync_out(dl_s));
	plcs_sync u_sync_spd (.mclk(mclk), .reset(reset),
		.async_in(speed_5g), .sync_out(spd_s));

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign pready   = 1'b1;
	assign wr_acc   = psel && penable && pwrite;
	assign rd_acc   = psel && penable && !pwrite;
	assign hit_link = (paddr == ADDR_LINK);
	assign pslverr  = psel && penable && !(hit_link
		|| paddr == plcs_pkg::IRQ_STATUS_ADDR
		|| paddr == plcs_pkg::IRQ_MASK_ADDR
		|| paddr == plcs_pkg::PORT_CFG_ADDR);

	// ----------------------------------------------------------------
	// port role
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (reset)
			is_down_q <= 1'b0;
		else if (wr_acc && paddr == plcs_pkg::PORT_CFG_ADDR && pstrb[0])
			is_down_q <= pwdata[0];
	end

	// ----------------------------------------------------------------
	// link control
	// ----------------------------------------------------------------
	assign rw_mask = is_down_q ? plcs_pkg::CTRL_RW_MASK_DS
		: plcs_pkg::CTRL_RW_MASK_US;
	assign wmask = rw_mask & {{8{pstrb[1]}}, {8{pstrb[0]}}};

	always_ff @(posedge mclk)
	begin
		if (reset)
			ctrl_q <= plcs_pkg::CTRL_RESET;
		else if (wr_acc && hit_link)
			ctrl_q <= (ctrl_q & ~wmask) | (pwdata[15:0] & wmask);
		else if (!is_down_q)
			ctrl_q <= ctrl_q & plcs_pkg::CTRL_RW_MASK_US;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			retrain_pulse <= 1'b0;
		else
			retrain_pulse <= wr_acc && hit_link && is_down_q && pstrb[0]
				&& pwdata[plcs_pkg::RETRAIN_BIT];
	end

	assign aspm_enable = ctrl_q[plcs_pkg::ASPM_LSB +: 2];
	assign rx_l0s_allowed = 1'b1;
	assign link_disable = ctrl_q[plcs_pkg::LINK_DIS_BIT] && is_down_q;
	assign common_clock = ctrl_q[plcs_pkg::COMMON_CLK_BIT];
	assign hw_width_change_inhibit = ctrl_q[plcs_pkg::HW_WIDTH_BIT];
	assign l0s_exit_fts = ctrl_q[plcs_pkg::EXT_SYNC_BIT]
		? plcs_pkg::FTS_EXT : 13'h0000;
	assign l1_exit_ts1 = ctrl_q[plcs_pkg::EXT_SYNC_BIT]
		? plcs_pkg::TS1_EXT : 13'h0000;

	// ----------------------------------------------------------------
	// link status
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			speed_q <= plcs_pkg::SPEED_5G;
			width_q <= plcs_pkg::WIDTH_RESET;
		end
		else if (width_valid)
		begin
			speed_q <= spd_s ? plcs_pkg::SPEED_5G
				: plcs_pkg::SPEED_2G5;
			width_q <= trained_width;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			terr_q <= 1'b0;
		else if (fail_s)
			terr_q <= 1'b1;
		else if (l0_s)
			terr_q <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			training_q   <= 1'b0;
			train_prev_q <= 1'b0;
		end
		else
		begin
			training_q   <= train_s;
			train_prev_q <= training_q;
		end
	end

	// strap is caught only once the synchroniser holds a real pin value
	always_ff @(posedge mclk)
	begin
		if (reset)
			strap_arm_q <= 2'b00;
		else
			strap_arm_q <= {strap_arm_q[0], 1'b1};
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			slot_clk_q   <= 1'b0;
			strap_done_q <= 1'b0;
		end
		else if (strap_arm_q[1] && !strap_done_q)
		begin
			slot_clk_q   <= strap_s;
			strap_done_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			dl_act_q      <= 1'b0;
			dl_act_prev_q <= 1'b0;
		end
		else
		begin
			dl_act_q      <= dl_s;
			dl_act_prev_q <= dl_act_q;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	assign irq_evt[plcs_pkg::IRQ_TERR]    = fail_s && !terr_q;
	assign irq_evt[plcs_pkg::IRQ_TDONE]   = train_prev_q && !training_q;
	assign irq_evt[plcs_pkg::IRQ_DL_UP]   = dl_act_q && !dl_act_prev_q;
	assign irq_evt[plcs_pkg::IRQ_DL_DOWN] = !dl_act_q && dl_act_prev_q;

	always_ff @(posedge mclk)
	begin
		if (reset)
			irq_sts_q <= '0;
		else if (rd_acc && paddr == plcs_pkg::IRQ_STATUS_ADDR)
			irq_sts_q <= irq_evt;
		else
			irq_sts_q <= irq_sts_q | irq_evt;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
			irq_mask_q <= '0;
		else if (wr_acc && paddr == plcs_pkg::IRQ_MASK_ADDR && pstrb[0])
			irq_mask_q <= pwdata[IRQ_W-1:0];
	end

	assign irq = |(irq_sts_q & irq_mask_q);

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (paddr)
			ADDR_LINK:
			begin
				rdata_d[15:0] = ctrl_q & rw_mask;
				rdata_d[plcs_pkg::RCB_BIT] = 1'b0;
				rdata_d[plcs_pkg::RETRAIN_BIT] = 1'b0;
				rdata_d[plcs_pkg::SPEED_LSB +: 4] = speed_q;
				rdata_d[plcs_pkg::WIDTH_LSB +: 6] = width_q;
				rdata_d[plcs_pkg::TRAIN_ERR_BIT] = terr_q;
				rdata_d[plcs_pkg::TRAINING_BIT] = training_q;
				rdata_d[plcs_pkg::SLOT_CLK_BIT] = slot_clk_q;
				rdata_d[plcs_pkg::DL_ACTIVE_BIT] = dl_act_q;
			end
			plcs_pkg::IRQ_STATUS_ADDR: rdata_d[IRQ_W-1:0] = irq_sts_q;
			plcs_pkg::IRQ_MASK_ADDR:   rdata_d[IRQ_W-1:0] = irq_mask_q;
			plcs_pkg::PORT_CFG_ADDR:   rdata_d[0] = is_down_q;
			default:                   rdata_d = 32'h0000_0000;
		endcase
	end

	assign prdata = rd_acc ? rdata_d : 32'h0000_0000;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_aspm_reset;
		@(posedge mclk) $fell(reset) |-> aspm_enable == plcs_pkg::ASPM_OFF;
	endproperty
	a_aspm_reset: assert property (p_aspm_reset)
		else $error("aspm not off after reset");

	property p_l0s_rx;
		@(posedge mclk) disable iff (reset) rx_l0s_allowed;
	endproperty
	a_l0s_rx: assert property (p_l0s_rx)
		else $error("rx l0s blocked");

	property p_rcb_zero;
		@(posedge mclk) disable iff (reset)
			(rd_acc && hit_link) |-> !prdata[3] && !prdata[5];
	endproperty
	a_rcb_zero: assert property (p_rcb_zero)
		else $error("rcb or retrain read nonzero");

	property p_up_nodis;
		@(posedge mclk) disable iff (reset) !is_down_q |-> !link_disable;
	endproperty
	a_up_nodis: assert property (p_up_nodis)
		else $error("upstream link disabled");

	property p_retrain;
		@(posedge mclk) disable iff (reset)
			(wr_acc && hit_link && pstrb[0] && pwdata[5] && is_down_q)
			|=> retrain_pulse ##1 !retrain_pulse;
	endproperty
	a_retrain: assert property (p_retrain)
		else $error("retrain pulse wrong");

	property p_up_noretrain;
		@(posedge mclk) disable iff (reset)
			!is_down_q |=> !retrain_pulse;
	endproperty
	a_up_noretrain: assert property (p_up_noretrain)
		else $error("upstream retrain");

	property p_ext_sync;
		@(posedge mclk) disable iff (reset)
			ctrl_q[7] |-> l0s_exit_fts == 13'h1000 && l1_exit_ts1 == 13'h0400;
	endproperty
	a_ext_sync: assert property (p_ext_sync)
		else $error("extended sync counts wrong");

	property p_terr;
		@(posedge mclk) disable iff (reset) fail_s |=> terr_q;
	endproperty
	a_terr: assert property (p_terr)
		else $error("training error not set");

	property p_dl;
		@(posedge mclk) disable iff (reset) dl_s |=> dl_act_q;
	endproperty
	a_dl: assert property (p_dl)
		else $error("dl active not reported");
endmodule // plcs_link_regs

// file: plcs_pkg.sv
package plcs_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] LINK_CTRL_STS_ADDR = 12'h0d0;
	localparam logic [11:0] IRQ_STATUS_ADDR    = 12'h100;
	localparam logic [11:0] IRQ_MASK_ADDR      = 12'h104;
	localparam logic [11:0] PORT_CFG_ADDR      = 12'h108;

	// ----------------------------------------------------------------
	// link control fields
	// ----------------------------------------------------------------
	localparam int ASPM_LSB       = 0;
	localparam int RCB_BIT        = 3;
	localparam int LINK_DIS_BIT   = 4;
	localparam int RETRAIN_BIT    = 5;
	localparam int COMMON_CLK_BIT = 6;
	localparam int EXT_SYNC_BIT   = 7;
	localparam int HW_WIDTH_BIT   = 9;
	localparam int DS_RW10_BIT    = 10;
	localparam int DS_RW11_BIT    = 11;
	localparam logic [15:0] CTRL_RW_MASK_DS = 16'h0ed3;
	localparam logic [15:0] CTRL_RW_MASK_US = 16'h02c3;
	localparam logic [15:0] CTRL_RESET      = 16'h0000;

	// ----------------------------------------------------------------
	// link status fields
	// ----------------------------------------------------------------
	localparam int SPEED_LSB      = 16;
	localparam int WIDTH_LSB      = 20;
	localparam int TRAIN_ERR_BIT  = 26;
	localparam int TRAINING_BIT   = 27;
	localparam int SLOT_CLK_BIT   = 28;
	localparam int DL_ACTIVE_BIT  = 29;
	localparam logic [3:0] SPEED_2G5   = 4'h1;
	localparam logic [3:0] SPEED_5G    = 4'h2;
	localparam logic [5:0] WIDTH_RESET = 6'h01;

	// ----------------------------------------------------------------
	// aspm encodings and exit sequence counts
	// ----------------------------------------------------------------
	localparam logic [1:0] ASPM_OFF  = 2'h0;
	localparam logic [1:0] ASPM_L0S  = 2'h1;
	localparam logic [1:0] ASPM_L1   = 2'h2;
	localparam logic [1:0] ASPM_BOTH = 2'h3;
	localparam logic [12:0] FTS_EXT  = 13'h1000;
	localparam logic [12:0] TS1_EXT  = 13'h0400;

	// ----------------------------------------------------------------
	// interrupt status bits
	// ----------------------------------------------------------------
	localparam int IRQ_W        = 4;
	localparam int IRQ_TERR     = 0;
	localparam int IRQ_TDONE    = 1;
	localparam int IRQ_DL_UP    = 2;
	localparam int IRQ_DL_DOWN  = 3;
endpackage

// file: plcs_sync.sv
`timescale 1ns/1ps
module plcs_sync
(
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic async_in,
	output logic      sync_out
);
	logic meta_q;

	// ----------------------------------------------------------------
	// two-stage synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			meta_q   <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // plcs_sync

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	typedef struct {logic [31:0] e; logic [31:0] m; logic r;} plcs_note_t;
	logic        mclk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        strap;
	logic        trn;
	logic        fail;
	logic        inl0;
	logic        dla;
	logic        s5;
	logic [5:0]  tw;
	logic        twv;
	logic        ldis;
	logic        rtp;
	logic [1:0]  aspm;
	logic        rxl0s;
	logic        cclk;
	logic        hwi;
	logic [12:0] fts;
	logic [12:0] ts1;
	logic        irq;
	int          errors;
	int          compares;
	int          rt_n;
	int          i;
	integer      seed;
	logic [31:0] d;
	plcs_note_t  q[$];
	plcs_note_t  n;

	plcs_link_regs i_plcs_link_regs (.mclk(mclk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.slot_clock_strap(strap), .ltssm_training(trn),
		.ltssm_train_fail(fail), .ltssm_in_l0(inl0), .dl_active(dla),
		.speed_5g(s5), .trained_width(tw), .width_valid(twv),
		.link_disable(ldis), .retrain_pulse(rtp), .aspm_enable(aspm),
		.rx_l0s_allowed(rxl0s), .common_clock(cclk),
		.hw_width_change_inhibit(hwi), .l0s_exit_fts(fts),
		.l1_exit_ts1(ts1), .irq(irq));

	task automatic tally_and_finish;
		if (errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic xfer(input logic [11:0] a, input logic w,
		input logic [31:0] wd);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		pstrb   <= 4'hf;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		xfer(a, 1'b1, wd);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic r);
		plcs_note_t t;
		t.e = e & m;
		t.m = m;
		t.r = r;
		q.push_back(t);
		xfer(a, 1'b0, 32'h0000_0000);
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge mclk);
		@(negedge mclk);
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog and read monitor
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial
	begin
		#(50 * 4000);
		errors++;
		tally_and_finish();
	end

	always @(posedge mclk)
	begin
		if (rtp === 1'b1)
			rt_n++;
		if (psel && penable && pready && !pwrite && q.size() > 0)
		begin
			n = q.pop_front();
			chk("prdata", n.e, prdata & n.m);
			chk("pslverr", {31'h0, n.r}, {31'h0, pslverr});
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		seed = 32'he89a;
		{reset, errors, compares, rt_n} = {1'b1, 96'h0};
		{psel, penable, pwrite, paddr, pwdata, pstrb} = 51'h0;
		{trn, fail, inl0, dla, s5, tw, twv} = 12'h0;
		strap = 1'b1;
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		repeat (6) @(posedge mclk);
		rd(12'h0d0, 32'h1012_0000, 32'hffff_ffff, 1'b0);
		rd(12'h100, 32'h0, 32'hffff_ffff, 1'b0);
		rd(12'h108, 32'h0, 32'hffff_ffff, 1'b0);
		rd(12'h0fc, 32'h0, 32'h0, 1'b1);
		wr(12'h0d0, 32'hffff_ffff);
		rd(12'h0d0, 32'h02c3, 32'hffff, 1'b0);
		settle(3);
		chk("link_disable", 32'h0, ldis);
		chk("retrains", 32'h0, rt_n);
		chk("aspm", 32'h3, aspm);
		chk("common_clock", 32'h1, cclk);
		chk("hw_inhibit", 32'h1, hwi);
		chk("fts", 32'd4096, fts);
		chk("ts1", 32'd1024, ts1);
		wr(12'h108, 32'h1);
		for (i = 0; i < 4; i++)
		begin
			d = $random(seed);
			d[1:0] = i[1:0];
			d[5] = 1'b0;
			wr(12'h0d0, d);
			rd(12'h0d0, d & 32'h0ed3, 32'hffff, 1'b0);
			settle(1);
			chk("aspm", i, aspm);
			chk("rx_l0s", 32'h1, rxl0s);
			chk("link_disable", d[4], ldis);
			chk("fts", d[7] ? 32'd4096 : 32'd0, fts);
			chk("ts1", d[7] ? 32'd1024 : 32'd0, ts1);
		end
		wr(12'h0d0, 32'h0020);
		rd(12'h0d0, 32'h0, 32'hffff, 1'b0);
		settle(2);
		chk("retrains", 32'h1, rt_n);
		wr(12'h104, 32'hf);
		trn <= 1'b1;
		settle(6);
		rd(12'h0d0, 32'h0800_0000, 32'h0c00_0000, 1'b0);
		fail <= 1'b1;
		settle(6);
		rd(12'h0d0, 32'h0c00_0000, 32'h0c00_0000, 1'b0);
		settle(1);
		chk("irq", 32'h1, irq);
		@(posedge mclk);
		{tw, twv} <= {6'h04, 1'b1};
		@(posedge mclk);
		{twv, trn, fail, inl0, dla} <= 5'b00011;
		settle(6);
		rd(12'h0d0, 32'h3041_0000, 32'h3fff_0000, 1'b0);
		rd(12'h100, 32'h7, 32'hf, 1'b0);
		rd(12'h100, 32'h0, 32'hffff_ffff, 1'b0);
		settle(1);
		chk("irq", 32'h0, irq);
		wr(12'h104, 32'h0);
		{dla, s5} <= 2'b01;
		settle(6);
		chk("irq", 32'h0, irq);
		rd(12'h0d0, 32'h0, 32'h2000_0000, 1'b0);
		rd(12'h100, 32'h8, 32'h8, 1'b0);
		@(posedge mclk);
		{tw, twv} <= {6'h02, 1'b1};
		@(posedge mclk);
		twv <= 1'b0;
		rd(12'h0d0, 32'h0022_0000, 32'h03ff_0000, 1'b0);
		settle(1);
		tally_and_finish();
	end
endmodule // testbench
